// >>> rtl/smbus_cfg_pkg.sv
// Constants shared by the SMBus configuration register bank
package smbus_cfg_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFF_BUS_ADDRESS = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h01;
    localparam logic [7:0] OFF_MASK_CTRL = 8'h02;
    // ****************************************
    // Reset values and write masks
    // ****************************************
    localparam logic [6:0] BUS_ADDRESS_RESET = 7'h17;
    localparam logic [7:0] MASK_CTRL_RESET = 8'h00;
    localparam logic [7:0] MASK_CTRL_WRITABLE = 8'hA7;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // ****************************************
    // Field positions of the mask/control register
    // ****************************************
    localparam int SLOW_EDGE_BIT = 7;
    localparam int POWER_DOWN_BIT = 5;
    localparam int MASK_FAULT_NEG_BIT = 2;
    localparam int MASK_FAULT_POS_BIT = 1;
    localparam int MASK_SIGNAL_BIT = 0;
    // ****************************************
    // Status layout and line sampling
    // ****************************************
    localparam logic [4:0] STATUS_UPPER_ZERO = 5'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] LINE_IDLE = 3'h3;
endpackage : smbus_cfg_pkg

// >>> rtl/smbus_line_if.sv
// Bus line events passed from the line sampler to the register core
`timescale 1ns/1ns
interface smbus_line_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
    logic chain_in;
    modport sense (output scl_rise, output scl_fall, output start, output stop,
        output sda, output chain_in);
    modport core (input scl_rise, input scl_fall, input start, input stop,
        input sda, input chain_in);
endinterface : smbus_line_if

// >>> rtl/smbus_line_sense.sv
// Two-stage sampling of the bus pins and chain reset, with bus condition detection
`timescale 1ns/1ns
module smbus_line_sense (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_reset_chain_in,
    smbus_line_if.sense lines
);
    // ****************************************
    // Synchronisers: bit 2 chain in, bit 1 scl, bit 0 sda
    // ****************************************
    logic [2:0] meta;
    logic [2:0] sync;
    logic [1:0] prev;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            meta <= smbus_cfg_pkg::LINE_IDLE;
            sync <= smbus_cfg_pkg::LINE_IDLE;
            prev <= smbus_cfg_pkg::LINE_IDLE[1:0];
        end else begin
            meta <= {i_reset_chain_in, i_scl, i_sda};
            sync <= meta;
            prev <= sync[1:0];
        end
    end

    // ****************************************
    // Edge and condition decode
    // ****************************************
    assign lines.scl_rise = sync[1] && !prev[1];
    assign lines.scl_fall = !sync[1] && prev[1];
    assign lines.start = sync[1] && prev[1] && prev[0] && !sync[0];
    assign lines.stop = sync[1] && prev[1] && !prev[0] && sync[0];
    assign lines.sda = sync[0];
    assign lines.chain_in = sync[2];
endmodule : smbus_line_sense

// >>> rtl/smbus_config_regs_addr_chain.sv
// SMBus configuration and status register bank with reset daisy chain
//
// Contract
// - Power-up address 17h; bit 0 reads zero
// - Address register write raises chain output
// - Answer only at newly written address
// - Chain input low holds reset, output low
// - Address lost on power loss
// - Status read-only; bits 2,1 termination faults
// - Status bit 0 signal present; 7:3 zero
// - Bit 7 edge rate unless pin high
// - Bit 5 power down; enable low forces
// - Unmasked negative fault pulls alarm low
// - Unmasked positive fault pulls alarm low
// - Unmasked missing signal pulls alarm low
// - Address and mask registers read/write, reset defaults
// - Open-drain alarm for any unmasked condition
// - Write: address, index, data, each acknowledged
// - Read: index, repeated start, byte, host NACK
`timescale 1ns/1ns
module smbus_config_regs_addr_chain (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire logic i_reset_chain_in,
    output logic o_reset_chain_out,
    input wire logic i_term_fault_negative,
    input wire logic i_term_fault_positive,
    input wire logic i_input_signal_present,
    input wire logic i_edge_rate_pin,
    input wire logic i_enable_pin,
    output logic o_slow_edge,
    output logic o_output_power_down,
    output logic o_alarm_n,
    output logic o_alarm_n_oe
);
    // ****************************************
    // Types and storage
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_HOST_ACK, ST_SKIP
    } bus_state_type;
    typedef enum logic [1:0] {BYTE_ADDR, BYTE_INDEX, BYTE_DATA} byte_kind_type;

    smbus_line_if lines ();
    bus_state_type state;
    byte_kind_type kind;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [2:0] bit_cnt;
    logic got_byte;
    logic read_mode;
    logic host_nack;
    logic [7:0] index;
    logic [6:0] bus_address_field;
    logic [7:0] mask_ctrl;
    logic chain_out;
    logic sda_oe;
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    logic slow_edge;
    logic power_down;
    logic alarm;

    smbus_line_sense line_sense (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .i_reset_chain_in(i_reset_chain_in),
        .lines(lines.sense)
    );

    // ****************************************
    // Status and control pin sampling
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pin_meta <= 5'h00;
            pin_sync <= 5'h00;
        end else begin
            pin_meta <= {i_enable_pin, i_edge_rate_pin, i_term_fault_negative,
                i_term_fault_positive, i_input_signal_present};
            pin_sync <= pin_meta;
        end
    end

    // ****************************************
    // Decode
    // ****************************************
    wire enable_s = pin_sync[4];
    wire edge_s = pin_sync[3];
    wire fault_neg_s = pin_sync[2];
    wire fault_pos_s = pin_sync[1];
    wire present_s = pin_sync[0];
    wire in_reset = !i_resetn || !lines.chain_in;
    wire [7:0] status_value = {smbus_cfg_pkg::STATUS_UPPER_ZERO,
        fault_neg_s, fault_pos_s, present_s};
    wire [7:0] address_value = {bus_address_field, 1'b0};
    wire [7:0] read_data = (index == smbus_cfg_pkg::OFF_BUS_ADDRESS) ? address_value :
        (index == smbus_cfg_pkg::OFF_STATUS) ? status_value :
        (index == smbus_cfg_pkg::OFF_MASK_CTRL) ? mask_ctrl : smbus_cfg_pkg::UNMAPPED_READ;
    wire byte_end = (state == ST_RECV) && lines.scl_fall && got_byte;
    wire addr_match = (shift[7:1] == bus_address_field);
    wire wr_strobe = byte_end && (kind == BYTE_DATA);
    wire wr_address = wr_strobe && (index == smbus_cfg_pkg::OFF_BUS_ADDRESS);
    wire wr_mask = wr_strobe && (index == smbus_cfg_pkg::OFF_MASK_CTRL);
    wire next_slow_edge = edge_s || mask_ctrl[smbus_cfg_pkg::SLOW_EDGE_BIT];
    wire next_power_down = !enable_s || mask_ctrl[smbus_cfg_pkg::POWER_DOWN_BIT];
    wire alarm_neg = fault_neg_s && !mask_ctrl[smbus_cfg_pkg::MASK_FAULT_NEG_BIT];
    wire alarm_pos = fault_pos_s && !mask_ctrl[smbus_cfg_pkg::MASK_FAULT_POS_BIT];
    wire alarm_sig = !present_s && !mask_ctrl[smbus_cfg_pkg::MASK_SIGNAL_BIT];
    wire next_alarm = alarm_neg || alarm_pos || alarm_sig;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (in_reset) begin
            bus_address_field <= smbus_cfg_pkg::BUS_ADDRESS_RESET;
            mask_ctrl <= smbus_cfg_pkg::MASK_CTRL_RESET;
            chain_out <= 1'b0;
        end else begin
            if (wr_address) begin
                bus_address_field <= shift[7:1];
                chain_out <= 1'b1;
            end
            if (wr_mask) begin
                mask_ctrl <= shift & smbus_cfg_pkg::MASK_CTRL_WRITABLE;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            slow_edge <= 1'b0;
            power_down <= 1'b1;
            alarm <= 1'b0;
        end else begin
            slow_edge <= next_slow_edge;
            power_down <= next_power_down;
            alarm <= next_alarm;
        end
    end

    // ****************************************
    // Bus transaction engine
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (in_reset) begin
            state <= ST_IDLE;
            kind <= BYTE_ADDR;
            shift <= 8'h00;
            tx <= 8'h00;
            bit_cnt <= 3'h0;
            got_byte <= 1'b0;
            read_mode <= 1'b0;
            host_nack <= 1'b0;
            index <= 8'h00;
            sda_oe <= 1'b0;
        end else if (lines.start) begin
            state <= ST_RECV;
            kind <= BYTE_ADDR;
            bit_cnt <= 3'h0;
            got_byte <= 1'b0;
            sda_oe <= 1'b0;
        end else if (lines.stop) begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE, ST_SKIP: begin
                    sda_oe <= 1'b0;
                end
                ST_RECV: begin
                    if (lines.scl_rise) begin
                        shift <= {shift[6:0], lines.sda};
                        bit_cnt <= bit_cnt + 3'h1;
                        got_byte <= (bit_cnt == smbus_cfg_pkg::LAST_BIT);
                    end else if (byte_end) begin
                        got_byte <= 1'b0;
                        if (kind == BYTE_ADDR && !addr_match) begin
                            state <= ST_SKIP;
                        end else begin
                            state <= ST_ACK;
                            sda_oe <= 1'b1;
                            if (kind == BYTE_ADDR) begin
                                read_mode <= shift[0];
                            end
                            if (kind == BYTE_INDEX) begin
                                index <= shift;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (lines.scl_fall) begin
                        bit_cnt <= 3'h0;
                        if (kind == BYTE_ADDR && read_mode) begin
                            state <= ST_SEND;
                            tx <= read_data;
                            sda_oe <= !read_data[7];
                        end else if (kind == BYTE_DATA) begin
                            state <= ST_SKIP;
                            sda_oe <= 1'b0;
                        end else begin
                            state <= ST_RECV;
                            kind <= (kind == BYTE_ADDR) ? BYTE_INDEX : BYTE_DATA;
                            sda_oe <= 1'b0;
                        end
                    end
                end
                ST_SEND: begin
                    if (lines.scl_fall) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == smbus_cfg_pkg::LAST_BIT) begin
                            state <= ST_HOST_ACK;
                            sda_oe <= 1'b0;
                        end else begin
                            tx <= {tx[6:0], 1'b0};
                            sda_oe <= !tx[6];
                        end
                    end
                end
                ST_HOST_ACK: begin
                    if (lines.scl_rise) begin
                        host_nack <= lines.sda;
                    end else if (lines.scl_fall) begin
                        if (host_nack) begin
                            state <= ST_SKIP;
                        end else begin
                            state <= ST_SEND;
                            tx <= read_data;
                            sda_oe <= !read_data[7];
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_sda = 1'b0;
    assign o_sda_oe = sda_oe;
    assign o_reset_chain_out = chain_out;
    assign o_slow_edge = slow_edge;
    assign o_output_power_down = power_down;
    assign o_alarm_n = 1'b0;
    assign o_alarm_n_oe = alarm;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence addr_write_seq;
        wr_address && lines.chain_in;
    endsequence

    sequence chain_release_seq;
        lines.chain_in && !chain_out;
    endsequence

    chain_hold_low_a: assert property (!lines.chain_in |=> !o_reset_chain_out)
        else $error("chain output high while chain input low");
    chain_raise_a: assert property (addr_write_seq |=> o_reset_chain_out)
        else $error("chain output not raised by address write");
    chain_stays_a: assert property (o_reset_chain_out && lines.chain_in |=> o_reset_chain_out)
        else $error("chain output dropped without reset");
    new_address_a: assert property (addr_write_seq |=> bus_address_field == $past(shift[7:1]))
        else $error("address field not updated by write");
    default_address_a: assert property (chain_release_seq |-> bus_address_field == 7'h17)
        else $error("default address wrong after chain reset");
    no_ack_reset_a: assert property (in_reset |=> !o_sda_oe)
        else $error("bus driven while in reset");
    ack_own_addr_a: assert property (byte_end && kind == BYTE_ADDR && !addr_match
        |=> (!o_sda_oe) [*2])
        else $error("foreign address acknowledged");
    mask_reserved_a: assert property (wr_mask |=> mask_ctrl[6] == 1'h0 && mask_ctrl[4:3] == 2'h0)
        else $error("reserved mask bits stored");
    edge_force_a: assert property (edge_s |=> o_slow_edge)
        else $error("slow edge not forced by pin");
    edge_select_a: assert property (!edge_s && !mask_ctrl[7] && $stable(mask_ctrl) |=> !o_slow_edge)
        else $error("fast edge not selected");
    power_force_a: assert property (!enable_s |=> o_output_power_down)
        else $error("output not powered down by enable");
    alarm_neg_a: assert property (fault_neg_s && !mask_ctrl[2] |=> o_alarm_n_oe)
        else $error("negative fault did not raise alarm");
    alarm_pos_a: assert property (fault_pos_s && !mask_ctrl[1] |=> o_alarm_n_oe)
        else $error("positive fault did not raise alarm");
    alarm_signal_a: assert property (!present_s && !mask_ctrl[0] |=> o_alarm_n_oe)
        else $error("missing signal did not raise alarm");
    alarm_quiet_a: assert property (!(fault_neg_s && !mask_ctrl[2])
        && !(fault_pos_s && !mask_ctrl[1]) && (present_s || mask_ctrl[0])
        |=> !o_alarm_n_oe)
        else $error("alarm raised with nothing unmasked");
    status_zero_a: assert property (index == 8'h01 |-> read_data[7:3] == 5'h00)
        else $error("status upper bits not zero");
endmodule : smbus_config_regs_addr_chain

// >>> dv/smbus_host_model.sv
// SMBus host model with one general-purpose output
`timescale 1ns/1ns
module smbus_host_model (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low,
    output logic o_host_general_output
);
    // ****************
    // Line conditions
    // ****************
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
        o_host_general_output = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge i_clk);
    endtask : wait_n
    task automatic set_host_general_output(input logic v);
        wait_n(1);
        o_host_general_output = v;
    endtask : set_host_general_output
    // Start when stop is 0, stop when 1
    task automatic cond(input logic stop);
        o_scl = 1'b0;
        wait_n(3);
        o_sda_low = stop;
        wait_n(3);
        o_scl = 1'b1;
        wait_n(4);
        o_sda_low = ~stop;
        wait_n(4);
    endtask : cond
    task automatic bit_x(input logic b, output logic r);
        o_scl = 1'b0;
        wait_n(3);
        o_sda_low = ~b;
        wait_n(3);
        o_scl = 1'b1;
        wait_n(3);
        r = i_sda;
        wait_n(3);
    endtask : bit_x
    // ****************
    // Bytes and transfers
    // ****************
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], r);
            rx[i] = r;
        end
        bit_x(last, r);
        ack = ~r;
    endtask : xfer
    task automatic write_reg(input logic [6:0] addr, input logic [7:0] idx,
        input logic [7:0] data, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        cond(1'b0);
        xfer({addr, 1'b0}, 1'b1, rx, a0);
        xfer(idx, 1'b1, rx, a1);
        xfer(data, 1'b1, rx, a2);
        cond(1'b1);
        ok = a0 & a1 & a2;
    endtask : write_reg
    task automatic read_reg(input logic [6:0] addr, input logic [7:0] idx,
        output logic [7:0] data, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, a3;
        cond(1'b0);
        xfer({addr, 1'b0}, 1'b1, rx, a0);
        xfer(idx, 1'b1, rx, a1);
        cond(1'b0);
        xfer({addr, 1'b1}, 1'b1, rx, a2);
        xfer(8'hFF, 1'b1, data, a3);
        cond(1'b1);
        ok = a0 & a1 & a2;
    endtask : read_reg
    task automatic read_pair(input logic [6:0] addr, input logic [7:0] idx,
        output logic [7:0] first, output logic [7:0] second, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, a3, a4;
        cond(1'b0);
        xfer({addr, 1'b0}, 1'b1, rx, a0);
        xfer(idx, 1'b1, rx, a1);
        cond(1'b0);
        xfer({addr, 1'b1}, 1'b1, rx, a2);
        xfer(8'hFF, 1'b0, first, a3);
        xfer(8'hFF, 1'b1, second, a4);
        cond(1'b1);
        ok = a0 & a1 & a2;
    endtask : read_pair
endmodule : smbus_host_model

// >>> dv/tb_smbus_config_regs_addr_chain.sv
// Self-checking bench for the register bank and its reset chain
`timescale 1ns/1ns
module tb_smbus_config_regs_addr_chain;
    logic i_clk, i_resetn, scl, host_low, host_general_output, sda_line, oe_a, oe_b;
    logic chain_a, chain_b, sda_a, ok;
    logic fault_neg, fault_pos, present, edge_pin, enable, slow, pwr_down, alarm_n, alarm_oe;
    logic [7:0] rd;
    logic [7:0] rd_next;
    logic [7:0] masks [7] = '{8'h00, 8'h80, 8'h20, 8'h04, 8'h02, 8'h01, 8'hA7};
    int n_mismatch = 0;
    int tests_run = 0;
    assign sda_line = ~(host_low | (oe_a & ~sda_a) | oe_b);
    smbus_host_model host_u (.i_clk(i_clk), .i_sda(sda_line), .o_scl(scl),
        .o_sda_low(host_low), .o_host_general_output(host_general_output));
    smbus_config_regs_addr_chain dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_scl(scl),
        .i_sda(sda_line), .o_sda(sda_a), .o_sda_oe(oe_a),
        .i_reset_chain_in(host_general_output), .o_reset_chain_out(chain_a),
        .i_term_fault_negative(fault_neg), .i_term_fault_positive(fault_pos),
        .i_input_signal_present(present), .i_edge_rate_pin(edge_pin), .i_enable_pin(enable),
        .o_slow_edge(slow), .o_output_power_down(pwr_down), .o_alarm_n(alarm_n),
        .o_alarm_n_oe(alarm_oe));
    smbus_config_regs_addr_chain next_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_scl(scl),
        .i_sda(sda_line), .o_sda(), .o_sda_oe(oe_b), .i_reset_chain_in(chain_a),
        .o_reset_chain_out(chain_b), .i_term_fault_negative(fault_neg),
        .i_term_fault_positive(fault_pos), .i_input_signal_present(present),
        .i_edge_rate_pin(edge_pin), .i_enable_pin(enable),
        .o_slow_edge(), .o_output_power_down(), .o_alarm_n(), .o_alarm_n_oe());
    // ****************
    // Clock, helpers and verdict
    // ****************
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic settle(input int n);
        repeat (n) @(negedge i_clk);
    endtask : settle
    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        tests_run++;
        if (seen !== expected) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, expected);
        end
    endtask : check
    function automatic logic [2:0] pins_exp(input logic [7:0] m, input logic [4:0] v);
        return {v[1] | m[7], ~v[0] | m[5], (v[4] & ~m[2]) | (v[3] & ~m[1]) | (~v[2] & ~m[0])};
    endfunction : pins_exp
    task automatic conclude;
        $display("mismatches %0d of %0d comparisons", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (100000) @(posedge i_clk);
        n_mismatch++;
        conclude();
    end
    // ****************
    // Main sequence
    // ****************
    initial begin
        i_resetn = 1'b0;
        {fault_neg, fault_pos, present, edge_pin, enable} = 5'h05;
        settle(20);
        check({6'h00, chain_a, pwr_down}, 8'h01);
        i_resetn = 1'b1;
        settle(6);
        host_u.write_reg(7'h17, 8'h00, 8'h2C, ok);
        check({6'h00, ok, chain_a}, 8'h00);
        host_u.set_host_general_output(1'b1);
        settle(6);
        host_u.read_reg(7'h17, 8'h00, rd, ok);
        check(rd, 8'h2E);
        check({6'h00, ok, chain_a}, 8'h02);
        host_u.read_reg(7'h17, 8'h02, rd, ok);
        check(rd, 8'h00);
        host_u.write_reg(7'h17, 8'h00, 8'h2C, ok);
        settle(4);
        check({6'h00, ok, chain_a}, 8'h03);
        host_u.write_reg(7'h17, 8'h00, 8'h2A, ok);
        settle(4);
        check({5'h00, ok, chain_a, chain_b}, 8'h07);
        host_u.read_reg(7'h16, 8'h00, rd, ok);
        check(rd, 8'h2C);
        host_u.read_reg(7'h15, 8'h00, rd, ok);
        check(rd, 8'h2A);
        host_u.write_reg(7'h17, 8'h02, 8'h00, ok);
        check({7'h00, ok}, 8'h00);
        for (int i = 0; i < 8; i++) begin
            {fault_neg, fault_pos, present} = i[2:0];
            settle(5);
            host_u.read_reg(7'h16, 8'h01, rd, ok);
            check(rd, {5'h00, i[2:0]});
        end
        host_u.write_reg(7'h16, 8'h01, 8'h00, ok);
        host_u.read_reg(7'h16, 8'h01, rd, ok);
        check(rd, 8'h07);
        host_u.read_reg(7'h16, 8'h05, rd, ok);
        check(rd, 8'h00);
        foreach (masks[k]) begin
            host_u.write_reg(7'h16, 8'h02, masks[k], ok);
            host_u.read_reg(7'h16, 8'h02, rd, ok);
            check(rd, masks[k]);
            for (int v = 0; v < 32; v++) begin
                {fault_neg, fault_pos, present, edge_pin, enable} = v[4:0];
                settle(5);
                check({5'h00, slow, pwr_down, alarm_oe},
                    {5'h00, pins_exp(masks[k], v[4:0])});
                check({6'h00, sda_a, alarm_n}, 8'h00);
            end
        end
        host_u.read_pair(7'h16, 8'h02, rd, rd_next, ok);
        check(rd, 8'hA7);
        check(rd_next, 8'hA7);
        check({7'h00, ok}, 8'h01);
        {fault_neg, fault_pos, present, edge_pin, enable} = 5'h05;
        host_u.set_host_general_output(1'b0);
        settle(6);
        check({6'h00, chain_a, chain_b}, 8'h00);
        host_u.set_host_general_output(1'b1);
        settle(6);
        host_u.read_reg(7'h17, 8'h00, rd, ok);
        check(rd, 8'h2E);
        host_u.read_reg(7'h17, 8'h02, rd, ok);
        check(rd, 8'h00);
        host_u.write_reg(7'h17, 8'h00, 8'h2C, ok);
        i_resetn = 1'b0;
        settle(20);
        check({7'h00, chain_a}, 8'h00);
        i_resetn = 1'b1;
        settle(6);
        host_u.read_reg(7'h17, 8'h00, rd, ok);
        check(rd, 8'h2E);
        conclude();
    end
endmodule : tb_smbus_config_regs_addr_chain
